// ===== dv/rrc_engine_tb.sv
// Self-checking bench for the reservation register command engine
`timescale 1ns/1ns
module rrc_engine_tb;
  logic sys_clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cq_ready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cq_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic mem_rd_valid, mem_rd_ready, mem_rdata_valid, persist_through_power_loss;
  logic [63:0] mem_rd_addr, mem_rdata;
  logic [15:0] cq_cid;
  logic [10:0] cq_status, st;
  int bad_count = 0, tests_run = 0, cycles = 0;
  // Free-running system clock, 8 ns period
  always #4 sys_clk = ~sys_clk;
  rrc_engine i_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr,
    .mem_rdata_valid, .mem_rdata, .cq_valid, .cq_ready, .cq_cid, .cq_status,
    .persist_through_power_loss);
  rrc_host_mem i_mem (.sys_clk, .rst, .slow, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr,
    .mem_rdata_valid, .mem_rdata);
  // Compares one value and counts it
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // Write cycle: each channel released at the edge that takes it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge sys_clk); // Fresh edge, so back-to-back calls never drive a signal twice
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask
  // Read cycle: address released when taken, data taken with rvalid
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge sys_clk); // Fresh edge, so back-to-back calls never drive a signal twice
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge sys_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask
  // Register write expected to be accepted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    chk(resp, rrc_pkg::RESP_OKAY);
  endtask
  // Command word with all other fields left zero
  function automatic logic [31:0] cdw(input logic [1:0] chg, input logic ign,
                                      input logic [2:0] act);
    return {chg, 26'h0, ign, act};
  endfunction
  // Loads a command, starts it, takes the completion a cycle after it appears
  task automatic run_cmd(input logic [31:0] c, input logic [63:0] p1, input logic [63:0] p2,
                         input logic [3:0] host, input logic sgl);
    logic seen;
    seen = 1'b0;
    wr(rrc_pkg::OFF_CFG, {20'h0, host, 7'h0, sgl});
    wr(rrc_pkg::OFF_CDW10, c);
    wr(rrc_pkg::OFF_PTR0, p1[31:0]);
    wr(rrc_pkg::OFF_PTR1, p1[63:32]);
    wr(rrc_pkg::OFF_PTR2, p2[31:0]);
    wr(rrc_pkg::OFF_PTR3, p2[63:32]);
    wr(rrc_pkg::OFF_CID, {16'h0, p1[15:0]});
    wr(rrc_pkg::OFF_CTRL, 32'h1);
    while (!seen) begin
      @(negedge sys_clk);
      seen = cq_valid && cq_ready;
      st = cq_status;
      if (seen) chk(cq_cid, p1[15:0]);
      @(posedge sys_clk);
      cq_ready <= cq_valid && !seen;
    end
  endtask
  // Unmapped places and the read-only persistence register
  task automatic t_bus();
    axi_read(8'h40, rd, resp);
    chk(resp, rrc_pkg::RESP_DECERR);
    chk(rd, 32'h0);
    axi_write(8'h44, 32'h1, resp);
    chk(resp, rrc_pkg::RESP_DECERR);
    axi_read(rrc_pkg::OFF_PERSIST, rd, resp);
    chk(rd, {31'h0, rrc_pkg::PERSIST_RESET});
  endtask
  // Register, replace and unregister one host, with key checks and persistence changes
  task automatic t_keys();
    run_cmd(cdw(rrc_pkg::CHG_SET, 1'b0, rrc_pkg::ACT_REGISTER), 64'h1000, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_OK);
    chk(persist_through_power_loss, 1'b1);
    chk(i_mem.log_q[1], 64'h1000);
    chk(i_mem.log_q[0], 64'h1008);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_UNREGISTER), 64'h1100, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_CONFLICT);
    run_cmd(cdw(rrc_pkg::CHG_CLEAR, 1'b0, rrc_pkg::ACT_REPLACE), 64'h1008, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_OK);
    chk(persist_through_power_loss, 1'b0);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_UNREGISTER), 64'h1008, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_CONFLICT);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b1, rrc_pkg::ACT_UNREGISTER), 64'h1300, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_OK);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_UNREGISTER), 64'h1010, 64'h0, 4'h1, 1'b0);
    chk(st, rrc_pkg::STS_CONFLICT);
  endtask
  // Every reserved action code and the reserved persistence code
  task automatic t_reserved();
    for (int a = 3; a < 8; a++) begin
      run_cmd(cdw(rrc_pkg::CHG_SET, 1'b0, 3'(a)), 64'h5000, 64'h0, 4'h4, 1'b0);
      chk(st, rrc_pkg::STS_BAD_FIELD);
      chk(persist_through_power_loss, 1'b0);
    end
    run_cmd(cdw(rrc_pkg::CHG_RSVD, 1'b0, rrc_pkg::ACT_REGISTER), 64'h5000, 64'h0, 4'h4, 1'b0);
    chk(st, rrc_pkg::STS_BAD_FIELD);
    run_cmd(cdw(rrc_pkg::CHG_SET, 1'b0, rrc_pkg::ACT_REGISTER), 64'h5000, 64'h0, 4'h4, 1'b0);
    chk(persist_through_power_loss, 1'b1);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_REGISTER), 64'h5000, 64'h0, 4'h5, 1'b0);
    chk(st, rrc_pkg::STS_OK);
    chk(persist_through_power_loss, 1'b1);
    axi_read(rrc_pkg::OFF_PERSIST, rd, resp);
    chk(rd[0], 1'b1);
    // Status register keeps the last completion until software clears done
    axi_read(rrc_pkg::OFF_STATUS, rd, resp);
    chk(rd[rrc_pkg::ST_CODE_LSB +: 11], rrc_pkg::STS_OK);
    chk(rd[rrc_pkg::ST_DONE_BIT], 1'b1);
    wr(rrc_pkg::OFF_STATUS, 32'h2);
    axi_read(rrc_pkg::OFF_STATUS, rd, resp);
    chk(rd[rrc_pkg::ST_DONE_BIT], 1'b0);
  endtask
  // Second beat across a page edge, page list against scatter-gather, slow memory
  task automatic t_pointer();
    slow <= 1'b1;
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_REGISTER), 64'h2ff8, 64'h9000, 4'h2, 1'b0);
    chk(st, rrc_pkg::STS_OK);
    chk(i_mem.log_q[0], 64'h9000);
    run_cmd(cdw(rrc_pkg::CHG_NONE, 1'b0, rrc_pkg::ACT_REGISTER), 64'h2ff8, 64'h9000, 4'h3, 1'b1);
    chk(st, rrc_pkg::STS_OK);
    chk(i_mem.log_q[0], 64'h3000);
  endtask
  // Reset, wait for the key table clear, then the scenarios
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd = 32'h1;
    while (rd[0] !== 1'b0) axi_read(rrc_pkg::OFF_CTRL, rd, resp);
    t_bus();
    t_keys();
    t_reserved();
    t_pointer();
    final_report();
  end
endmodule

// ===== dv/rrc_host_mem.sv
// Host memory model that serves key structure reads
`timescale 1ns/1ns
module rrc_host_mem (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_rd_valid,
  output logic mem_rd_ready,
  input wire logic [63:0] mem_rd_addr,
  output logic mem_rdata_valid,
  output logic [63:0] mem_rdata
);
  logic pend_q; // A read waits for its data beat
  logic [3:0] wait_q; // Cycles left before the beat
  logic [63:0] addr_q; // Address of the pending read
  logic [63:0] log_q [2]; // Last two addresses taken, newest first
  // One read at a time
  assign mem_rd_ready = !pend_q;
  // Beat carries a key made from its address; idle data toggles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      addr_q <= 64'h0;
      mem_rdata_valid <= 1'b0;
      mem_rdata <= 64'h0;
    end else if (mem_rd_valid && !pend_q) begin
      pend_q <= 1'b1;
      addr_q <= mem_rd_addr;
      log_q[1] <= log_q[0];
      log_q[0] <= mem_rd_addr;
      wait_q <= slow ? 4'h6 : 4'h0;
      mem_rdata_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (pend_q && wait_q == 4'h0) begin
      pend_q <= 1'b0;
      mem_rdata_valid <= 1'b1;
      mem_rdata <= {~addr_q[31:0], addr_q[31:0]};
    end else begin
      wait_q <= wait_q - 4'h1;
      mem_rdata_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ===== verilog/rrc_engine.sv
// Reservation register command engine with AXI4-Lite control
// Operation
// R1: Post completion with status when done
// R2: Key structure via dword 10 and pointer
// R3: Scatter-gather uses only first entry
// R4: Host treats other command fields reserved
// R5: 128-bit pointer locates the key structure
// R6: Dword 10 bits 31:30 change persistence
// R7: 00b keeps persistence, 01b reserved
// R8: 10b clears persistence state
// R9: 11b sets persistence state
// R10: Bit 3 skips current key check
// R11: Bits 2:0 select register/unregister/replace
// R12: Bytes 7:0 hold current key
// R13: Bytes 15:8 hold new key
// R14: Reserved codes complete with invalid field
`timescale 1ns/1ns
module rrc_engine #(
  parameter int HOST_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_rd_valid,
  input wire logic mem_rd_ready,
  output logic [63:0] mem_rd_addr,
  input wire logic mem_rdata_valid,
  input wire logic [63:0] mem_rdata,
  output logic cq_valid,
  input wire logic cq_ready,
  output logic [15:0] cq_cid,
  output logic [10:0] cq_status,
  output logic persist_through_power_loss
);
  typedef enum logic [2:0] {
    S_INIT = 3'b000, S_IDLE = 3'b001, S_DECODE = 3'b010, S_FETCH = 3'b011,
    S_LOOKUP = 3'b100, S_EXEC = 3'b101, S_POST = 3'b110
  } rrc_state_e;
  rrc_state_e st_q; // Command sequencer state
  // Software registers
  logic [31:0] cdw10_q;
  logic [127:0] buffer_pointer_q;
  logic sgl_q, done_q; // Scatter-gather select, sticky done
  logic [HOST_W-1:0] host_q, init_q; // Issuing host, table clear index
  logic [15:0] cid_q;
  logic [10:0] sts_q;
  // Bus bookkeeping
  logic aw_have_q, w_have_q; // Write address or data held
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, go, clr_done, busy;
  // Decoded command fields
  logic [1:0] persist_state_change;
  logic ignore_existing_key_flag;
  logic [2:0] register_action;
  // Fetch and table signals
  logic fetch_start, fetch_done, tbl_we, ent_valid;
  logic [63:0] current_key, new_key, ent_key; // Fetched keys, stored key
  logic [HOST_W-1:0] tbl_waddr;
  logic [64:0] tbl_wdata, tbl_rdata, exec_wdata; // Valid bit on top
  logic [10:0] exec_sts;
  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // True for an address this slave decodes
  function automatic logic mapped(input logic [7:0] a);
    return (a <= rrc_pkg::OFF_PERSIST) && (a[1:0] == 2'b00);
  endfunction

  assign busy = (st_q != S_IDLE);
  assign persist_state_change = cdw10_q[rrc_pkg::CDW_CHG_LSB +: 2]; // [R6]
  assign ignore_existing_key_flag = cdw10_q[rrc_pkg::CDW_IGN_BIT];
  assign register_action = cdw10_q[2:0]; // [R11]

  // Write channel handshakes: address and data accepted in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign go = wr_fire && (awaddr_q == rrc_pkg::OFF_CTRL) && wstrb_q[0]
              && wdata_q[rrc_pkg::CTRL_GO_BIT] && !busy;
  assign clr_done = wr_fire && (awaddr_q == rrc_pkg::OFF_STATUS) && wstrb_q[0]
                    && wdata_q[rrc_pkg::ST_DONE_BIT];

  // Capture write address and data, then answer with one response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rrc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? rrc_pkg::RESP_OKAY : rrc_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command registers; changes while busy are ignored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cdw10_q <= 32'h0;
      buffer_pointer_q <= 128'h0;
      sgl_q <= 1'b0;
      host_q <= '0;
      cid_q <= 16'h0;
    end else if (wr_fire && !busy) begin
      unique case (awaddr_q)
        rrc_pkg::OFF_CDW10: cdw10_q <= merge(cdw10_q, wdata_q, wstrb_q); // [R2]
        rrc_pkg::OFF_PTR0: buffer_pointer_q[31:0] <= merge(buffer_pointer_q[31:0],
                                                           wdata_q, wstrb_q);
        rrc_pkg::OFF_PTR1: buffer_pointer_q[63:32] <= merge(buffer_pointer_q[63:32],
                                                            wdata_q, wstrb_q);
        rrc_pkg::OFF_PTR2: buffer_pointer_q[95:64] <= merge(buffer_pointer_q[95:64],
                                                            wdata_q, wstrb_q);
        rrc_pkg::OFF_PTR3: buffer_pointer_q[127:96] <= merge(buffer_pointer_q[127:96],
                                                             wdata_q, wstrb_q);
        rrc_pkg::OFF_CFG: begin
          if (wstrb_q[0]) sgl_q <= wdata_q[rrc_pkg::CFG_SGL_BIT];
          if (wstrb_q[1]) host_q <= wdata_q[rrc_pkg::CFG_HOST_LSB +: HOST_W];
        end
        rrc_pkg::OFF_CID: cid_q <= 16'(merge({16'h0, cid_q}, wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // Read channel: registered data, one response per address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? rrc_pkg::RESP_OKAY : rrc_pkg::RESP_DECERR;
      unique case (s_axi_araddr)
        rrc_pkg::OFF_CTRL: s_axi_rdata <= {31'h0, busy};
        rrc_pkg::OFF_CDW10: s_axi_rdata <= cdw10_q;
        rrc_pkg::OFF_PTR0: s_axi_rdata <= buffer_pointer_q[31:0];
        rrc_pkg::OFF_PTR1: s_axi_rdata <= buffer_pointer_q[63:32];
        rrc_pkg::OFF_PTR2: s_axi_rdata <= buffer_pointer_q[95:64];
        rrc_pkg::OFF_PTR3: s_axi_rdata <= buffer_pointer_q[127:96];
        rrc_pkg::OFF_CFG: s_axi_rdata <= 32'({host_q, 7'h0, sgl_q});
        rrc_pkg::OFF_CID: s_axi_rdata <= {16'h0, cid_q};
        rrc_pkg::OFF_STATUS: s_axi_rdata <= {5'h0, sts_q, 14'h0, done_q, busy};
        rrc_pkg::OFF_PERSIST: s_axi_rdata <= {31'h0, persist_through_power_loss};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Outcome of the table check for the decoded action
  assign ent_valid = tbl_rdata[64];
  assign ent_key = tbl_rdata[63:0];
  always_comb begin
    exec_sts = rrc_pkg::STS_OK;
    exec_wdata = tbl_rdata;
    unique case (register_action)
      rrc_pkg::ACT_REGISTER: begin
        if (ent_valid && (ent_key != new_key)) exec_sts = rrc_pkg::STS_CONFLICT;
        exec_wdata = {1'b1, new_key}; // [R13]
      end
      rrc_pkg::ACT_UNREGISTER: begin
        if (!ent_valid || (!ignore_existing_key_flag && ent_key != current_key)) begin
          exec_sts = rrc_pkg::STS_CONFLICT; // [R10] [R12]
        end
        exec_wdata = 65'h0;
      end
      default: begin
        if (!ent_valid || (!ignore_existing_key_flag && ent_key != current_key)) begin
          exec_sts = rrc_pkg::STS_CONFLICT; // [R10] [R12]
        end
        exec_wdata = {1'b1, new_key};
      end
    endcase
  end

  assign fetch_start = (st_q == S_DECODE) && (register_action <= rrc_pkg::ACT_REPLACE)
                       && (persist_state_change != rrc_pkg::CHG_RSVD);
  assign tbl_we = (st_q == S_INIT) || ((st_q == S_EXEC) && (exec_sts == rrc_pkg::STS_OK));
  assign tbl_waddr = (st_q == S_INIT) ? init_q : host_q;
  assign tbl_wdata = (st_q == S_INIT) ? 65'h0 : exec_wdata;

  // Command sequencer, including a clearing pass over the table after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_INIT;
      init_q <= '0;
      sts_q <= rrc_pkg::STS_OK;
    end else begin
      unique case (st_q)
        S_INIT: begin
          init_q <= init_q + 1'b1;
          if (&init_q) st_q <= S_IDLE;
        end
        S_IDLE: if (go) st_q <= S_DECODE;
        S_DECODE: begin
          if (!fetch_start) sts_q <= rrc_pkg::STS_BAD_FIELD; // [R14]
          st_q <= fetch_start ? S_FETCH : S_POST;
        end
        S_FETCH: if (fetch_done) st_q <= S_LOOKUP;
        S_LOOKUP: st_q <= S_EXEC;
        S_EXEC: begin
          sts_q <= exec_sts;
          st_q <= S_POST;
        end
        S_POST: if (cq_ready) st_q <= S_IDLE; // [R1]
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Persistence state follows the change field after a successful action
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      persist_through_power_loss <= rrc_pkg::PERSIST_RESET;
    end else if (st_q == S_EXEC && exec_sts == rrc_pkg::STS_OK) begin
      if (persist_state_change == rrc_pkg::CHG_CLEAR) begin
        persist_through_power_loss <= 1'b0; // [R8]
      end else if (persist_state_change == rrc_pkg::CHG_SET) begin
        persist_through_power_loss <= 1'b1; // [R9]
      end
      // No change for the keep code [R7]
    end
  end

  // Sticky done flag; a new completion wins over a software clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (st_q == S_POST && cq_ready) begin
      done_q <= 1'b1;
    end else if (clr_done) begin
      done_q <= 1'b0;
    end
  end

  // Completion entry toward the I/O completion queue
  assign cq_valid = (st_q == S_POST); // [R1]
  assign cq_cid = cid_q;
  assign cq_status = sts_q;

  rrc_key_fetch u_fetch (
    .sys_clk(sys_clk), .rst(rst), .start(fetch_start), .sgl_mode(sgl_q),
    .buffer_pointer(buffer_pointer_q), .mem_rd_valid(mem_rd_valid),
    .mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr),
    .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata),
    .current_key(current_key), .new_key(new_key), .done(fetch_done)
  );
  rrc_key_store #(.AW(HOST_W), .DW(65)) u_keys (
    .sys_clk(sys_clk), .we(tbl_we), .waddr(tbl_waddr), .wdata(tbl_wdata),
    .raddr(host_q), .rdata_q(tbl_rdata)
  );

  // Reserved codes never reach the host memory fetch
  a_rsvd_no_fetch: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
    (st_q == S_DECODE && register_action > rrc_pkg::ACT_REPLACE) |=> st_q == S_POST
    && cq_status == rrc_pkg::STS_BAD_FIELD) else $error("reserved action not rejected");
  a_chg_rsvd_err: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (st_q == S_DECODE && persist_state_change == rrc_pkg::CHG_RSVD) |=>
    cq_status == rrc_pkg::STS_BAD_FIELD) else $error("reserved change code accepted");
  a_persist_clear: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    (st_q == S_EXEC && exec_sts == rrc_pkg::STS_OK
     && persist_state_change == rrc_pkg::CHG_CLEAR) |=> !persist_through_power_loss)
    else $error("persistence not cleared");
  a_persist_set: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    (st_q == S_EXEC && exec_sts == rrc_pkg::STS_OK
     && persist_state_change == rrc_pkg::CHG_SET) |=> persist_through_power_loss)
    else $error("persistence not set");
  a_persist_keep: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (st_q != S_EXEC || persist_state_change == rrc_pkg::CHG_NONE) |=>
    $stable(persist_through_power_loss)) else $error("persistence changed unasked");
  a_cq_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    (cq_valid && !cq_ready) |=> cq_valid && $stable(cq_status) && $stable(cq_cid))
    else $error("completion dropped before taken");
  a_ignore_key: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (st_q == S_EXEC && ignore_existing_key_flag && ent_valid
     && register_action == rrc_pkg::ACT_UNREGISTER) |=> cq_status == rrc_pkg::STS_OK)
    else $error("key checked despite ignore flag");
  a_key_mismatch: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
    (st_q == S_EXEC && !ignore_existing_key_flag && register_action != rrc_pkg::ACT_REGISTER
     && ent_key != current_key) |=> cq_status == rrc_pkg::STS_CONFLICT)
    else $error("wrong current key accepted");
  a_first_addr: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (st_q == S_DECODE && fetch_start) |=> ##[0:2] (mem_rd_valid
    && mem_rd_addr == buffer_pointer_q[63:0])) else $error("fetch from wrong address");
  a_exec_post: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    (st_q == S_FETCH && fetch_done) |=> ##2 cq_valid) else $error("no completion after fetch");
endmodule

// ===== verilog/rrc_key_fetch.sv
// Reads the 16-byte key structure from host memory in two 8-byte beats
`timescale 1ns/1ns
module rrc_key_fetch (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic sgl_mode,
  input wire logic [127:0] buffer_pointer,
  output logic mem_rd_valid,
  input wire logic mem_rd_ready,
  output logic [63:0] mem_rd_addr,
  input wire logic mem_rdata_valid,
  input wire logic [63:0] mem_rdata,
  output logic [63:0] current_key,
  output logic [63:0] new_key,
  output logic done
);
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_REQ = 2'b01,
    F_DATA = 2'b10
  } rrc_fetch_e;
  rrc_fetch_e st_q;
  logic beat_q;
  logic [63:0] addr1;
  logic [63:0] addr_next;

  // Second beat: page list moves to the second entry on a page crossing,
  // scatter-gather uses only the first entry
  assign addr_next = buffer_pointer[63:0] + 64'h8;
  always_comb begin
    addr1 = addr_next;
    if (!sgl_mode && (addr_next[rrc_pkg::PAGE_BITS-1:0] == '0)) begin // [R2]
      addr1 = buffer_pointer[127:64];
    end
  end

  // First beat always starts at the low pointer half [R5] [R3]
  assign mem_rd_addr = beat_q ? addr1 : buffer_pointer[63:0];
  assign mem_rd_valid = (st_q == F_REQ);

  // Beat sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= F_IDLE;
      beat_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        F_IDLE: begin
          beat_q <= 1'b0;
          if (start) st_q <= F_REQ;
        end
        F_REQ: if (mem_rd_ready) st_q <= F_DATA;
        F_DATA: begin
          if (mem_rdata_valid) begin
            beat_q <= ~beat_q;
            st_q <= beat_q ? F_IDLE : F_REQ;
            done <= beat_q;
          end
        end
        default: st_q <= F_IDLE;
      endcase
    end
  end

  // Bytes 7:0 current key, bytes 15:8 new key
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      current_key <= 64'h0;
      new_key <= 64'h0;
    end else if (st_q == F_DATA && mem_rdata_valid) begin
      if (beat_q) new_key <= mem_rdata; // [R13]
      else current_key <= mem_rdata; // [R12]
    end
  end
endmodule

// ===== verilog/rrc_key_store.sv
// Registrant key table with registered read data
`timescale 1ns/1ns
module rrc_key_store #(
  parameter int AW = 4,
  parameter int DW = 65
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  // Storage array, valid bit in the top position
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port; entries start invalid through the init pass in the engine
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    rdata_q <= mem[raddr];
  end
endmodule

// ===== verilog/rrc_pkg.sv
// Constants shared by the reservation register command engine
package rrc_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CDW10 = 8'h04;
  localparam logic [7:0] OFF_PTR0 = 8'h08;
  localparam logic [7:0] OFF_PTR1 = 8'h0c;
  localparam logic [7:0] OFF_PTR2 = 8'h10;
  localparam logic [7:0] OFF_PTR3 = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_CID = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_PERSIST = 8'h24;
  // Field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CFG_SGL_BIT = 0;
  localparam int CFG_HOST_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_CODE_LSB = 16;
  localparam int CDW_CHG_LSB = 30;
  localparam int CDW_IGN_BIT = 3;
  // Register action codes
  localparam logic [2:0] ACT_REGISTER = 3'h0;
  localparam logic [2:0] ACT_UNREGISTER = 3'h1;
  localparam logic [2:0] ACT_REPLACE = 3'h2;
  // Persistence change codes
  localparam logic [1:0] CHG_NONE = 2'h0;
  localparam logic [1:0] CHG_RSVD = 2'h1;
  localparam logic [1:0] CHG_CLEAR = 2'h2;
  localparam logic [1:0] CHG_SET = 2'h3;
  // Completion status {type, code}
  localparam logic [10:0] STS_OK = 11'h000;
  localparam logic [10:0] STS_BAD_FIELD = 11'h002;
  localparam logic [10:0] STS_CONFLICT = 11'h083;
  // Page size for the page-list pointer split
  localparam int PAGE_BITS = 12;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Reset values
  localparam logic PERSIST_RESET = 1'b0;
endpackage
